/* verilog/pss_sequencer.sv */
`timescale 1ns/1ps
// Switching sequencer for a boost power-factor stage.
// Assumes digitized comparator inputs synchronous to ref_clk and an 8-bit comp level code.
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int BROWNOUT_CYCLES = BROWNOUT_CYC,
    parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   supply_on,
    input  wire logic                   mains_above_brown_in,
    input  wire logic                   mains_below_brown_out,
    input  wire logic                   out_undershoot,
    input  wire logic                   out_overshoot,
    input  wire logic                   valley_above_high,
    input  wire logic                   valley_below_low,
    input  wire logic                   sense_over_limit,
    input  wire logic                   sense_over_fault,
    input  wire logic [pss_pkg::LW-1:0] internal_comp_level,
    output logic                        gate,
    output logic                        comp_discharge,
    output logic                        soft_start,
    output pss_pkg::pss_gain_t          amp_gain,
    output logic                        low_power,
    output logic                        soft_pulse,
    output logic                        brownout,
    output logic                        overcurrent_fault
);
    import pss_pkg::*;

    pss_if tif ();

    pss_off_timer u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tif     (tif)
    );

    pss_state_t    state;
    pss_state_t    next_state;
    logic          enabled;
    logic          next_enabled;
    logic          running;
    logic          next_running;
    logic          next_brownout;
    logic [TW-1:0] bo_cnt;
    logic [TW-1:0] next_bo_cnt;
    logic [TW-1:0] rec_cnt;
    logic [TW-1:0] next_rec_cnt;
    logic          next_fault;
    logic          fault_hit;
    logic          next_fault_hit;
    logic          prev_fault_hit;
    logic          next_prev_fault_hit;
    logic          armed;
    logic          next_armed;
    logic [TW-1:0] tcnt;
    logic [TW-1:0] next_tcnt;
    logic          by_timeout;
    logic          next_by_timeout;
    logic          bursting;
    logic          next_bursting;
    logic [2:0]    soft_cnt;
    logic [2:0]    next_soft_cnt;
    logic          next_gate;
    logic          next_comp_discharge;
    logic          next_soft_start;
    pss_gain_t     next_amp_gain;
    logic          next_soft_pulse;
    logic [TW-1:0] dead_cyc;
    logic          brown_in_evt;
    logic          brownout_evt;
    logic          allowed;
    logic          turn_off;
    logic          fault_seen;

    // Dead time grows linearly as the comp level falls toward the crossover.
    function automatic logic [TW-1:0] dead_for(input logic [LW-1:0] lvl);
        logic [TW-1:0] span;
        span = '0;
        if (lvl <= CROSSOVER_CODE) begin
            span = TW'(DEAD_MAX_CYC);                                 // R12
        end else if (lvl < CROSSOVER_CODE + 8'h40) begin
            span = TW'((DEAD_MAX_CYC * (CROSSOVER_CODE + 8'h40 - lvl)) / 64); // R11
        end
        return span;
    endfunction

    assign dead_cyc     = dead_for(internal_comp_level);
    assign tif.dead_cyc = dead_cyc;
    assign brown_in_evt = enabled && !running && mains_above_brown_in;
    assign brownout_evt = running && (bo_cnt == TW'(BROWNOUT_CYCLES - 1));
    // Lockout acts at once.
    assign allowed      = supply_on && enabled && running && !overcurrent_fault
                          && !(bursting && soft_cnt == 3'd0);         // R21
    assign turn_off     = (state == PSS_ON) && (next_state != PSS_ON);
    assign tif.start    = turn_off;
    // Hits in the cycle that ends the pulse count too.
    assign fault_seen   = fault_hit || (state == PSS_ON && sense_over_fault
                          && tcnt >= TW'(FAULT_BLANK_CYC));           // R18

    // Enable, brown-in and brownout supervision.
    always_comb begin
        next_enabled        = supply_on;                              // R1
        next_running        = running;
        next_brownout       = brownout;
        next_bo_cnt         = '0;
        next_comp_discharge = comp_discharge;
        next_soft_start     = 1'b0;
        if (!supply_on) begin
            next_running        = 1'b0;
            next_brownout       = 1'b0;
            next_comp_discharge = 1'b1;
        end else if (brown_in_evt) begin
            next_running        = 1'b1;                               // R1
            next_brownout       = 1'b0;
            next_comp_discharge = 1'b0;
            next_soft_start     = 1'b1;                               // R4
        end else if (running && mains_below_brown_out) begin
            next_bo_cnt = bo_cnt + 1'b1;                              // R2
            if (brownout_evt) begin
                next_running        = 1'b0;
                next_brownout       = 1'b1;
                next_comp_discharge = 1'b1;                           // R3
                next_bo_cnt         = '0;
            end
        end
    end

    // Over-current fault latch and recovery timer.
    always_comb begin
        next_fault          = overcurrent_fault;
        next_rec_cnt        = '0;
        next_fault_hit      = fault_hit;
        next_prev_fault_hit = prev_fault_hit;
        if (state == PSS_ON && tcnt >= TW'(FAULT_BLANK_CYC) && sense_over_fault) begin
            next_fault_hit = 1'b1;                                    // R18
        end
        if (turn_off) begin
            next_fault_hit = 1'b0;
            // Only timeout restarts take part in the count.
            if (by_timeout) begin
                next_prev_fault_hit = fault_seen;
                if (fault_seen && prev_fault_hit) begin
                    next_fault = 1'b1;                                // R19
                end
            end
        end
        if (overcurrent_fault) begin
            next_rec_cnt = rec_cnt + 1'b1;
            if (rec_cnt == TW'(RECOVERY_CYCLES - 1)) begin
                next_fault   = 1'b0;                                  // R20
                next_rec_cnt = '0;
            end
        end
        if (!supply_on || brown_in_evt || brownout_evt) begin
            next_fault          = 1'b0;                               // R20
            next_rec_cnt        = '0;
            next_prev_fault_hit = 1'b0;
        end
    end

    // Burst control with soft-off and soft-on pulse counts.
    always_comb begin
        next_bursting   = bursting;
        next_soft_cnt   = soft_cnt;
        next_soft_pulse = 1'b0;
        if (!running) begin
            next_bursting = 1'b0;
            next_soft_cnt = '0;
        end else if (!bursting && internal_comp_level < BURST_STOP_CODE) begin
            next_bursting = 1'b1;
            next_soft_cnt = 3'(SOFT_PULSES);                          // R13
        end else if (bursting && soft_cnt == 3'd0
                     && internal_comp_level >= BURST_RESUME_CODE) begin
            next_bursting = 1'b0;
            next_soft_cnt = 3'(SOFT_PULSES);                          // R14
        end else if (turn_off && soft_cnt != 3'd0) begin
            next_soft_cnt   = soft_cnt - 1'b1;
            next_soft_pulse = 1'b1;
        end
    end

    // Error-amplifier gain select.
    always_comb begin
        next_amp_gain = PSS_GAIN_X1;
        if (out_overshoot) begin
            next_amp_gain = PSS_GAIN_X8;                              // R6
        end else if (out_undershoot) begin
            next_amp_gain = PSS_GAIN_X4;                              // R5
        end
    end

    // Gate sequencing.
    always_comb begin
        next_state      = state;
        next_tcnt       = tcnt + 1'b1;
        next_armed      = armed;
        next_by_timeout = by_timeout;
        next_gate       = 1'b0;
        unique case (state)
            PSS_OFF: begin
                next_tcnt = '0;
                if (allowed) begin
                    next_state = PSS_WAIT;
                end
            end
            PSS_WAIT: begin
                next_tcnt = '0;
                if (tif.blank_done && valley_above_high) begin
                    next_armed = 1'b1;                                // R7
                end
                if (tif.timeout) begin
                    next_state      = PSS_DELAY;                      // R10
                    next_by_timeout = 1'b1;
                end else if (tif.dead_done && armed && valley_below_low) begin
                    next_state      = PSS_DELAY;                      // R8
                    next_by_timeout = 1'b0;
                end
            end
            PSS_DELAY: begin
                if (tcnt >= TW'(VALLEY_DELAY_CYC - 1)) begin
                    next_state = PSS_ON;                              // R9
                    next_tcnt  = '0;
                    next_gate  = 1'b1;
                end
            end
            PSS_ON: begin
                next_gate = 1'b1;
                if ((tcnt >= TW'(LIMIT_BLANK_CYC) && sense_over_limit) // R17
                    || tcnt >= TW'(ON_TIME_CYC - 1)) begin
                    next_state = PSS_PARKED;                          // R16
                    next_gate  = 1'b0;
                    next_armed = 1'b0;
                end
            end
            PSS_PARKED: begin
                next_tcnt  = '0;
                next_state = PSS_WAIT;
            end
            default: begin
                next_state = PSS_OFF;
            end
        endcase
        if (!allowed) begin
            next_state = (state == PSS_ON) ? PSS_PARKED : PSS_OFF;    // R21
            next_gate  = 1'b0;
            // Arming never survives a stop.
            next_armed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state             <= PSS_OFF;
            enabled           <= 1'b0;
            running           <= 1'b0;
            brownout          <= 1'b0;
            bo_cnt            <= '0;
            rec_cnt           <= '0;
            overcurrent_fault <= 1'b0;
            fault_hit         <= 1'b0;
            prev_fault_hit    <= 1'b0;
            armed             <= 1'b0;
            tcnt              <= '0;
            by_timeout        <= 1'b0;
            bursting          <= 1'b0;
            soft_cnt          <= '0;
            gate              <= 1'b0;
            comp_discharge    <= 1'b1;
            soft_start        <= 1'b0;
            amp_gain          <= PSS_GAIN_X1;
            soft_pulse        <= 1'b0;
        end else begin
            state             <= next_state;
            enabled           <= next_enabled;
            running           <= next_running;
            brownout          <= next_brownout;
            bo_cnt            <= next_bo_cnt;
            rec_cnt           <= next_rec_cnt;
            overcurrent_fault <= next_fault;
            fault_hit         <= next_fault_hit;
            prev_fault_hit    <= next_prev_fault_hit;
            armed             <= next_armed;
            tcnt              <= next_tcnt;
            by_timeout        <= next_by_timeout;
            bursting          <= next_bursting;
            soft_cnt          <= next_soft_cnt;
            gate              <= next_gate;
            comp_discharge    <= next_comp_discharge;
            soft_start        <= next_soft_start;
            amp_gain          <= next_amp_gain;
            soft_pulse        <= next_soft_pulse;
        end
    end

    // Most internal blocks sleep while bursting with no soft pulses left.
    assign low_power = bursting && (soft_cnt == 3'd0);                // R15
endmodule

/* verilog/pss_pkg.sv */
// Constants, types and timing counts for the switching sequencer.
// Assumes a single 25 MHz clock and comparator inputs already synchronous to it.
// How it works
// (R1) Enable at supply turn-on, then switch only after mains peak exceeds brown-in.
// (R2) Mains below brownout level keeps switching until a 50 ms timer expires.
// (R3) Confirmed brownout stops switching and forces the compensation node to zero.
// (R4) After brownout, restart with soft-start once mains peak exceeds brown-in again.
// (R5) Output undershoot of 4 percent selects four times error-amplifier gain.
// (R6) Output deviation of 4 percent overshoot selects eight times gain.
// (R7) Valley input is ignored for 0.3 us after every gate turn-off.
// (R8) Valley needs the input above the high level, then below the low level.
// (R9) Turn-on waits for dead-time end and valley, then a 150 ns delay.
// (R10) No valley within 180 us after turn-off forces a turn-on.
// (R11) Dead time grows as load falls, limited to a 23 us maximum.
// (R12) Dead time is maximum when compensation level reaches the crossover threshold.
// (R13) Compensation below burst-stop level stops switching after five soft-off pulses.
// (R14) Compensation back at burst-resume level resumes with five soft-on pulses.
// (R15) Burst-off powers down most internal functions.
// (R16) Sense above current limit ends the present on-pulse.
// (R17) Current-limit comparison is blanked 300 ns after each turn-on.
// (R18) Fault comparison uses its own shorter 250 ns blanking.
// (R19) Fault level in two consecutive timeout-restart cycles latches the fault and stops.
// (R20) Fault clears after 80 ms, or on brown-in, brownout or lockout.
// (R21) Gate is low in brownout, burst-off, fault, lockout or before enable.
package pss_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 40;

    localparam int VALLEY_BLANK_NS    = 300;
    localparam int VALLEY_DELAY_NS    = 150;
    localparam int RESTART_TIMEOUT_NS = 180_000;
    localparam int DEAD_MAX_NS        = 23_000;
    localparam int LIMIT_BLANK_NS     = 300;
    localparam int FAULT_BLANK_NS     = 250;
    localparam int BROWNOUT_MS        = 50;
    localparam int RECOVERY_MS        = 80;
    localparam int ON_TIME_NS         = 10_000;

    // Least times round up, longest times round down.
    localparam int VALLEY_BLANK_CYC = (VALLEY_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int VALLEY_DELAY_CYC = (VALLEY_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESTART_CYC      = RESTART_TIMEOUT_NS / CLK_NS;
    localparam int DEAD_MAX_CYC     = DEAD_MAX_NS / CLK_NS;
    localparam int LIMIT_BLANK_CYC  = (LIMIT_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAULT_BLANK_CYC  = (FAULT_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int BROWNOUT_CYC     = BROWNOUT_MS * (CLK_HZ / 1000);
    localparam int RECOVERY_CYC     = RECOVERY_MS * (CLK_HZ / 1000);
    localparam int ON_TIME_CYC      = ON_TIME_NS / CLK_NS;

    localparam int SOFT_PULSES      = 5;
    localparam int TW               = 24;
    localparam int LW               = 8;

    // Compensation level code: 1 LSB = 2 mV of internal comp level.
    localparam logic [LW-1:0] CROSSOVER_CODE = 8'hbe;
    localparam logic [LW-1:0] BURST_STOP_CODE = 8'h1e;
    localparam logic [LW-1:0] BURST_RESUME_CODE = 8'h3c;

    typedef enum logic [1:0] {
        PSS_GAIN_X1 = 2'b00,
        PSS_GAIN_X4 = 2'b01,
        PSS_GAIN_X8 = 2'b10
    } pss_gain_t;

    typedef enum logic [2:0] {
        PSS_OFF    = 3'b000,
        PSS_WAIT   = 3'b001,
        PSS_DELAY  = 3'b010,
        PSS_ON     = 3'b011,
        PSS_PARKED = 3'b100
    } pss_state_t;
endpackage

/* verilog/pss_if.sv */
`timescale 1ns/1ps
// Timer hand-off between the sequencer and its off-time timer.
// Assumes both ends share the sequencer clock.
interface pss_if;
    import pss_pkg::*;
    logic          start;
    logic [TW-1:0] dead_cyc;
    logic          blank_done;
    logic          dead_done;
    logic          timeout;
    modport seq   (output start, output dead_cyc, input blank_done, input dead_done,
                   input timeout);
    modport timer (input start, input dead_cyc, output blank_done, output dead_done,
                   output timeout);
endinterface

/* verilog/pss_off_timer.sv */
`timescale 1ns/1ps
// Off-time timer: counts from gate turn-off for blanking, dead time and timeout.
// Assumes start is a one-cycle pulse at each turn-off.
module pss_off_timer
    import pss_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    pss_if.timer      tif
);
    logic [TW-1:0] count;
    logic [TW-1:0] next_count;

    always_comb begin
        next_count = count;
        if (tif.start) begin
            next_count = '0;
        end else if (count < TW'(RESTART_CYC)) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= TW'(RESTART_CYC);
        end else begin
            count <= next_count;
        end
    end

    assign tif.blank_done = count >= TW'(VALLEY_BLANK_CYC); // R7
    assign tif.dead_done  = count >= tif.dead_cyc;           // R11
    assign tif.timeout    = count >= TW'(RESTART_CYC);      // R10
endmodule

/* bench/pss_stage_model.sv */
`timescale 1ns/1ps
// Boost stage stand-in: auxiliary winding comparators and current sense comparators.
// Assumes the sequencer gate output and the bench clock.
module pss_stage_model (
    input  wire logic ref_clk,
    input  wire logic gate,
    input  wire logic ring_en,
    input  wire logic limit_en,
    input  wire logic fault_en,
    output logic      valley_above_high,
    output logic      valley_below_low,
    output logic      sense_over_limit,
    output logic      sense_over_fault
);
    int on_cnt = 0;
    int off_cnt = 0;
    always @(posedge ref_clk) begin
        on_cnt  <= gate ? on_cnt + 1 : 0;
        off_cnt <= gate ? 0 : off_cnt + 1;
    end
    // Demagnetising lasts 20 cycles, then the winding rings below the low level.
    assign valley_above_high = ring_en && !gate && off_cnt < 20;
    assign valley_below_low  = !valley_above_high;
    // Inductor current crosses both sense levels late in each pulse.
    assign sense_over_limit  = limit_en && gate && on_cnt >= 20;
    assign sense_over_fault  = fault_en && gate && on_cnt >= 20;
endmodule

/* bench/pss_seq_assertions.sv */
`timescale 1ns/1ps
// Port checker for the switching sequencer.
// Assumes one clock domain and the synchronous active-high reset.
module pss_seq_assertions
    import pss_pkg::*;
(
    input wire logic      ref_clk,
    input wire logic      reset,
    input wire logic      supply_on,
    input wire logic      mains_above_brown_in,
    input wire logic      out_undershoot,
    input wire logic      out_overshoot,
    input wire logic      gate,
    input wire logic      comp_discharge,
    input wire logic      soft_start,
    input pss_pkg::pss_gain_t amp_gain,
    input wire logic      low_power,
    input wire logic      brownout,
    input wire logic      overcurrent_fault
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_gain_x8; out_overshoot |=> amp_gain == PSS_GAIN_X8; endproperty
    a_gain_x8: assert property (p_gain_x8)
        else $error("gain not x8 after overshoot");
    property p_gain_x4; out_undershoot && !out_overshoot |=> amp_gain == PSS_GAIN_X4; endproperty
    a_gain_x4: assert property (p_gain_x4)
        else $error("gain not x4 after undershoot");
    property p_bo_off; brownout && $past(brownout) |-> !gate && comp_discharge; endproperty
    a_bo_off: assert property (p_bo_off)
        else $error("switching or comp released in brownout");
    property p_fault_off; overcurrent_fault && $past(overcurrent_fault) |-> !gate; endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("gate high while fault latched");
    property p_sleep; low_power |-> !gate; endproperty
    a_sleep: assert property (p_sleep)
        else $error("gate high in burst sleep");
    property p_lockout; !supply_on ##1 !supply_on |-> !gate; endproperty
    a_lockout: assert property (p_lockout)
        else $error("gate high in lockout");
    property p_soft; soft_start |-> $past(mains_above_brown_in); endproperty
    a_soft: assert property (p_soft)
        else $error("soft start without brown-in");
    property p_blank; $fell(gate) |-> !gate[*8]; endproperty
    a_blank: assert property (p_blank)
        else $error("turn-on inside valley blanking");
    property p_min_on; $fell(gate) && !brownout && !low_power |-> $past(gate, 7); endproperty
    a_min_on: assert property (p_min_on)
        else $error("pulse ended inside limit blanking");
endmodule

bind pss_sequencer pss_seq_assertions u_pss_chk (
    .ref_clk(ref_clk), .reset(reset), .supply_on(supply_on),
    .mains_above_brown_in(mains_above_brown_in), .out_undershoot(out_undershoot),
    .out_overshoot(out_overshoot), .gate(gate), .comp_discharge(comp_discharge),
    .soft_start(soft_start), .amp_gain(amp_gain), .low_power(low_power),
    .brownout(brownout), .overcurrent_fault(overcurrent_fault)
);

/* bench/tb_pss_sequencer.sv */
`timescale 1ns/1ps
// Self-checking bench for the switching sequencer driven by a boost stage model.
// Assumes shortened brownout and recovery counts set at the instance.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_pss_sequencer;
    import pss_pkg::*;
    localparam int BO_CYC = 200;
    localparam int RC_CYC = 300;
    logic ref_clk, reset, supply_on, mains_above_brown_in, mains_below_brown_out;
    logic out_undershoot, out_overshoot, valley_above_high, valley_below_low;
    logic sense_over_limit, sense_over_fault, ring, lim, flt;
    logic [LW-1:0] level;
    logic gate, comp_discharge, soft_start, low_power, soft_pulse, brownout, ovf;
    pss_gain_t amp_gain;
    int checked = 0;
    int n_mismatch = 0;

    pss_sequencer #(.BROWNOUT_CYCLES(BO_CYC), .RECOVERY_CYCLES(RC_CYC)) dut (
        .ref_clk(ref_clk), .reset(reset), .supply_on(supply_on),
        .mains_above_brown_in(mains_above_brown_in),
        .mains_below_brown_out(mains_below_brown_out),
        .out_undershoot(out_undershoot), .out_overshoot(out_overshoot),
        .valley_above_high(valley_above_high), .valley_below_low(valley_below_low),
        .sense_over_limit(sense_over_limit), .sense_over_fault(sense_over_fault),
        .internal_comp_level(level), .gate(gate), .comp_discharge(comp_discharge),
        .soft_start(soft_start), .amp_gain(amp_gain), .low_power(low_power),
        .soft_pulse(soft_pulse), .brownout(brownout), .overcurrent_fault(ovf)
    );
    pss_stage_model u_stage (
        .ref_clk(ref_clk), .gate(gate), .ring_en(ring), .limit_en(lim), .fault_en(flt),
        .valley_above_high(valley_above_high), .valley_below_low(valley_below_low),
        .sense_over_limit(sense_over_limit), .sense_over_fault(sense_over_fault)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task automatic wt(input logic v, input int lim_n, output int n);
        n = 0;
        while (gate !== v && n < lim_n) begin
            step(1);
            n++;
        end
        if (n >= lim_n) `CHK("gate wait", 1'b1, 1'b0)
    endtask
    // Times one whole pulse: cycles high, then cycles low up to the next turn-on.
    task automatic pulse(output int hi, output int lo);
        int n;
        wt(1'b1, 6000, n);
        wt(1'b0, 6000, hi);
        wt(1'b1, 6000, lo);
    endtask
    task automatic wsoft();
        int n = 0;
        while (soft_start !== 1'b1 && n < 6) begin
            step(1);
            n++;
        end
    endtask
    task automatic count_soft(output int n);
        n = 0;
        repeat (5000) begin
            step(1);
            if (soft_pulse === 1'b1) n++;
        end
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic t_start();
        step(20);
        `CHK("gate lockout", 1'b0, gate)
        supply_on = 1'b1;
        step(30);
        `CHK("gate before brown-in", 1'b0, gate)
        mains_above_brown_in = 1'b1;
        wsoft();
        `CHK("soft_start", 1'b1, soft_start)
        step(1);
        `CHK("comp released", 1'b0, comp_discharge)
        done("start");
    endtask
    task automatic t_gain();
        pss_gain_t exp_g[4] = '{PSS_GAIN_X1, PSS_GAIN_X4, PSS_GAIN_X8, PSS_GAIN_X8};
        for (int i = 0; i < 4; i++) begin
            {out_overshoot, out_undershoot} = 2'(i);
            step(2);
            `CHK("amp_gain", exp_g[i], amp_gain)
        end
        {out_overshoot, out_undershoot} = 2'b00;
        done("gain");
    endtask
    task automatic t_timeout();
        int hi, lo;
        pulse(hi, lo);
        pulse(hi, lo);
        `CHK("restart", 1'b1, lo >= RESTART_CYC && lo <= RESTART_CYC + 8)
        done("timeout");
    endtask
    task automatic t_valley();
        int hi, lo;
        ring = 1'b1;
        lim = 1'b1;
        pulse(hi, lo);
        pulse(hi, lo);
        `CHK("limit on time", 1'b1, hi >= 20 && hi <= 24)
        `CHK("valley gap", 1'b1, lo >= 20 + VALLEY_DELAY_CYC && lo <= 28)
        done("valley");
    endtask
    task automatic t_dead();
        int hi, lo;
        level = CROSSOVER_CODE;
        pulse(hi, lo);
        pulse(hi, lo);
        `CHK("dead max", 1'b1, lo >= DEAD_MAX_CYC && lo <= DEAD_MAX_CYC + 10)
        level = CROSSOVER_CODE + 8'h20;
        pulse(hi, lo);
        pulse(hi, lo);
        `CHK("dead mid", 1'b1, lo > 40 && lo < DEAD_MAX_CYC)
        level = 8'hff;
        done("dead");
    endtask
    task automatic t_burst();
        int n;
        level = BURST_STOP_CODE - 8'h01;
        count_soft(n);
        `CHK("soft off count", 5, n)
        `CHK("sleep", 1'b1, low_power)
        level = BURST_RESUME_CODE - 8'h01;
        step(200);
        `CHK("hysteresis", 1'b1, low_power)
        level = BURST_RESUME_CODE;
        count_soft(n);
        `CHK("soft on count", 5, n)
        `CHK("awake", 1'b0, low_power)
        level = 8'hff;
        done("burst");
    endtask
    task automatic t_brown();
        int k = 0;
        int r = 0;
        logic pg = gate;
        mains_above_brown_in = 1'b0;
        mains_below_brown_out = 1'b1;
        while (brownout !== 1'b1 && k < BO_CYC + 50) begin
            step(1);
            k++;
            if (k < BO_CYC - 50 && gate && !pg) r++;
            pg = gate;
        end
        `CHK("switch in timer", 1'b1, r > 0)
        `CHK("bo time", 1'b1, k >= BO_CYC && k <= BO_CYC + 3)
        step(50);
        `CHK("bo gate", 1'b0, gate)
        `CHK("bo comp", 1'b1, comp_discharge)
        mains_below_brown_out = 1'b0;
        mains_above_brown_in = 1'b1;
        wsoft();
        `CHK("bo restart", 1'b1, soft_start)
        step(1);
        `CHK("bo cleared", 1'b0, brownout)
        done("brownout");
    endtask
    task automatic t_fault();
        int n = 0;
        int hi, lo;
        ring = 1'b0;
        flt = 1'b1;
        pulse(hi, lo);
        `CHK("one hit", 1'b0, ovf)
        `CHK("hit gap", 1'b1, lo >= RESTART_CYC && lo <= RESTART_CYC + 8)
        while (ovf !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        `CHK("fault set", 1'b1, ovf)
        `CHK("fault end", 1'b1, n >= 20 && n <= 24)
        n = 0;
        while (ovf === 1'b1 && n < RC_CYC + 20) begin
            step(1);
            n++;
        end
        `CHK("recovery", 1'b1, n >= RC_CYC - 3 && n <= RC_CYC + 1)
        flt = 1'b0;
        supply_on = 1'b0;
        step(2);
        `CHK("lockout gate", 1'b0, gate)
        done("fault");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {reset, supply_on, mains_above_brown_in, mains_below_brown_out} = 4'b1000;
        {out_undershoot, out_overshoot, ring, lim, flt} = 5'b00000;
        level = 8'hff;
        repeat (6) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_start();
        t_gain();
        t_timeout();
        t_valley();
        t_dead();
        t_burst();
        t_brown();
        t_fault();
        summarize();
    end
endmodule
